/* hdl/adc_cfg_consts.vh */
// constants for the serial configuration port of the octal converter
// assumes a 200 MHz core clock; included by bare name from hdl/
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH

`define CFG_ADDR_W 8
`define CFG_DATA_W 16
`define CFG_WORD_BITS 24
`define CFG_CNT_W 5
`define CFG_CNT_ZERO 5'h00
`define CFG_CNT_ONE 5'h01
`define CFG_CNT_LAST 5'h17
`define CFG_ADDR_MSB 23
`define CFG_ADDR_LSB 16
`define CFG_DATA_MSB 15
`define CFG_REG_DEFAULT 16'h0000
`define CFG_SWRST_ADDR 8'h00
`define CFG_SWRST_BIT 0
`define CFG_PD_ADDR 8'h0F
`define CFG_PD_BIT 9
`define CFG_SLEEP_BIT 8
`define CFG_CHPD_MSB 7
`define CFG_CHPD_LSB 0
`define CFG_REG_COUNT 64
`define CFG_CLK_PERIOD_NS 5
`define CFG_PIN_PULSE_MIN_NS 20
`define CFG_PIN_PULSE_MIN_CYC ((`CFG_PIN_PULSE_MIN_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)
`define CFG_SHIFT_CLK_MAX_MHZ 20

`endif

/* hdl/sync_bits.v */
// two-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level or a clock far below mclk
`timescale 1ns/1ps
module sync_bits
#(
    parameter WIDTH = 4
)
(
    input wire mclk,
    input wire reset_n,
    input wire [WIDTH-1:0] async,
    output wire [WIDTH-1:0] synced
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;

// stage1 feeds stage2 only
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        stage1 <= {WIDTH{1'b0}};
        stage2 <= {WIDTH{1'b0}};
    end
    else
    begin
        stage1 <= async;
        stage2 <= stage1;
    end
end

assign synced = stage2;

endmodule // sync_bits

/* hdl/adc_serial_config_port.v */
// serial configuration port: shifts 24-bit address/data words into a register bank
// assumes shift clock, select, data and the two init pins come from outside mclk's domain
`timescale 1ns/1ps
`include "adc_cfg_consts.vh"
module adc_serial_config_port
#(
    parameter REG_COUNT = `CFG_REG_COUNT
)
(
    input wire mclk,
    input wire reset_n,
    input wire cfgShiftClk,
    input wire cfg_select_n,
    input wire cfg_serial_in,
    input wire hw_reset_n,
    input wire power_down_control,
    output wire [REG_COUNT*`CFG_DATA_W-1:0] regBank,
    output reg writeStrobe,
    output reg [`CFG_ADDR_W-1:0] writeAddr,
    output reg [`CFG_DATA_W-1:0] writeData,
    output reg softResetPulse,
    output reg powerDownActive,
    output reg sleepActive,
    output reg [`CFG_CHPD_MSB:`CFG_CHPD_LSB] channelPowerDown,
    output reg powerDownInitDone,
    output reg partialWordDropped
);

localparam CNT_W = `CFG_CNT_W;

// shift clock, select, data and power-down pins pass two flops; the reset pin and power_down_control also act directly as async controls
wire [3:0] pinSynced;
wire shiftClkS;
wire selectNS;
wire serialInS;
wire pdPinS;

sync_bits #(
    .WIDTH(4)
) pinSync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async({power_down_control, cfg_serial_in, cfg_select_n, cfgShiftClk}),
    .synced(pinSynced)
);

assign shiftClkS = pinSynced[0];
assign selectNS = pinSynced[1];
assign serialInS = pinSynced[2];
assign pdPinS = pinSynced[3];

// register reset: chip reset or the reset pin, asserted at once, released in step with mclk;
// the pin acts without the shift clock, so it works straight after power-up
wire regRstAsyncN;
reg regRstMeta;
reg regRstN;

assign regRstAsyncN = reset_n & hw_reset_n;

always @(posedge mclk or negedge regRstAsyncN)
begin
    if (!regRstAsyncN)
    begin
        regRstMeta <= 1'b0;
        regRstN <= 1'b0;
    end
    else
    begin
        regRstMeta <= 1'b1;
        regRstN <= regRstMeta;
    end
end

// shift clock edge detection on the synchronised copy;
// data and clock see the same two-flop delay so setup/hold at the pins carry over
reg shiftClkD;
wire shiftRise;

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        shiftClkD <= 1'b0;
    end
    else
    begin
        shiftClkD <= shiftClkS;
    end
end

// at 20 MHz a shift period spans ten mclk cycles, so no edge is missed
assign shiftRise = shiftClkS & ~shiftClkD;

// shifter and bit counter
reg [`CFG_WORD_BITS-2:0] shiftReg;
reg [CNT_W-1:0] bitCount;
reg [CNT_W-1:0] next_bitCount;
reg commitNow;
wire [`CFG_WORD_BITS-1:0] fullWord;

assign fullWord = {shiftReg, serialInS};

always @*
begin
    next_bitCount = bitCount;
    commitNow = 1'b0;
    if (selectNS)
    begin
        next_bitCount = `CFG_CNT_ZERO;
    end
    else if (shiftRise)
    begin
        if (bitCount == `CFG_CNT_LAST)
        begin
            // each complete group is its own write; the counter wraps for the next word
            commitNow = 1'b1;
            next_bitCount = `CFG_CNT_ZERO;
        end
        else
        begin
            next_bitCount = bitCount + `CFG_CNT_ONE;
        end
    end
end

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        shiftReg <= {(`CFG_WORD_BITS-1){1'b0}};
        bitCount <= `CFG_CNT_ZERO;
        partialWordDropped <= 1'b0;
    end
    else
    begin
        bitCount <= next_bitCount;
        if (!selectNS && shiftRise)
        begin
            shiftReg <= fullWord[`CFG_WORD_BITS-2:0];
        end
        // trailing bits short of a full word never reach the bank
        if (selectNS && bitCount != `CFG_CNT_ZERO)
        begin
            partialWordDropped <= 1'b1;
        end
        else if (commitNow)
        begin
            partialWordDropped <= 1'b0;
        end
    end
end

// write stage: address from the first eight bits, data from the last sixteen
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        writeStrobe <= 1'b0;
        writeAddr <= {`CFG_ADDR_W{1'b0}};
        writeData <= `CFG_REG_DEFAULT;
    end
    else
    begin
        writeStrobe <= commitNow;
        if (commitNow)
        begin
            writeAddr <= fullWord[`CFG_ADDR_MSB:`CFG_ADDR_LSB];
            writeData <= fullWord[`CFG_DATA_MSB:0];
        end
    end
end

// software reset: the bit is never stored, so it reads back as zero at once
wire softResetHit;

assign softResetHit = writeStrobe && (writeAddr == `CFG_SWRST_ADDR)
    && writeData[`CFG_SWRST_BIT];

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        softResetPulse <= 1'b0;
    end
    else
    begin
        softResetPulse <= softResetHit;
    end
end

// register bank; addresses at or above REG_COUNT are ignored
genvar i;
generate
    for (i = 0; i < REG_COUNT; i = i + 1)
    begin : bankEntry
        localparam integer IDX_FULL = i;
        // explicit cut: entries stay inside the eight-bit address range
        localparam [`CFG_ADDR_W-1:0] IDX = IDX_FULL[`CFG_ADDR_W-1:0];
        reg [`CFG_DATA_W-1:0] value;
        always @(posedge mclk or negedge regRstN)
        begin
            if (!regRstN)
            begin
                value <= `CFG_REG_DEFAULT;
            end
            else if (softResetHit)
            begin
                value <= `CFG_REG_DEFAULT;
            end
            else if (writeStrobe && writeAddr == IDX)
            begin
                value <= writeData;
            end
        end
        assign regBank[i*`CFG_DATA_W +: `CFG_DATA_W] = value;
    end
endgenerate

// power-down control word
wire [`CFG_DATA_W-1:0] pdWord;
wire pdBit;
reg pdBitD;

assign pdWord = regBank[`CFG_PD_ADDR*`CFG_DATA_W +: `CFG_DATA_W];
assign pdBit = pdWord[`CFG_PD_BIT];

always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
    begin
        pdBitD <= 1'b0;
        powerDownActive <= 1'b0;
        sleepActive <= 1'b0;
        channelPowerDown <= {(`CFG_CHPD_MSB-`CFG_CHPD_LSB+1){1'b0}};
    end
    else
    begin
        pdBitD <= pdBit;
        powerDownActive <= pdBit | pdPinS;
        sleepActive <= pdWord[`CFG_SLEEP_BIT];
        channelPowerDown <= pdWord[`CFG_CHPD_MSB:`CFG_CHPD_LSB];
    end
end

// power-down initialised: the pin sets it with no clock needed; the register path
// counts once the bit has gone high and back low
always @(posedge mclk or negedge reset_n or posedge power_down_control)
begin
    if (!reset_n)
    begin
        powerDownInitDone <= 1'b0;
    end
    else if (power_down_control)
    begin
        powerDownInitDone <= 1'b1;
    end
    else if (pdBitD && !pdBit)
    begin
        powerDownInitDone <= 1'b1;
    end
end

endmodule // adc_serial_config_port

/* verification/host_link.sv */
// host side of the link: drives select, shift clock and data
// assumes tasks are called by one process at a time
`timescale 1ns/1ps
module host_link
(
    output reg cfgShiftClk,
    output reg cfg_select_n,
    output reg cfg_serial_in
);
    initial
    begin
        cfgShiftClk = 1'b0;
        cfg_select_n = 1'b1;
        cfg_serial_in = 1'b0;
    end
    task open_frame;
    begin
        cfg_select_n = 1'b0;
        #12;
    end
    endtask
    // data settles 12 ns before the rise, holds 36 ns after it
    task shift_bit(input b);
    begin
        cfg_serial_in = b;
        #12 cfgShiftClk = 1'b1;
        #24 cfgShiftClk = 1'b0;
        #12;
    end
    endtask
    // clock stands low; released data flips so a stale level cannot pass
    task close_frame;
    begin
        #12 cfg_select_n = 1'b1;
        cfg_serial_in = ~cfg_serial_in;
    end
    endtask
endmodule // host_link

/* verification/adc_serial_config_port_asserts.sv */
// checker on the configuration port outputs
// assumes the constants header is on the include path
`timescale 1ns/1ps
`include "adc_cfg_consts.vh"
module adc_serial_config_port_asserts
#(
    parameter REG_COUNT = `CFG_REG_COUNT
)
(
    input wire mclk,
    input wire reset_n,
    input wire hw_reset_n,
    input wire power_down_control,
    input wire [REG_COUNT*`CFG_DATA_W-1:0] regBank,
    input wire writeStrobe,
    input wire [`CFG_ADDR_W-1:0] writeAddr,
    input wire [`CFG_DATA_W-1:0] writeData,
    input wire softResetPulse,
    input wire powerDownActive,
    input wire powerDownInitDone
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    wire softHit = writeStrobe && writeAddr == 8'h00 && writeData[0];
    chk_strobe_single: assert property (writeStrobe |=> !writeStrobe)
        else $error("strobe too long");
    chk_bank_write: assert property (writeStrobe && !softHit && hw_reset_n &&
        writeAddr < REG_COUNT |=> regBank[writeAddr*16 +: 16] == $past(writeData))
        else $error("bank not written");
    chk_soft_clear: assert property (softHit |=> regBank == '0 ##[0:1] softResetPulse)
        else $error("soft reset missed");
    chk_soft_self: assert property (softResetPulse |=> !softResetPulse)
        else $error("soft pulse stuck");
    chk_hw_clear: assert property (!hw_reset_n [*2] |-> regBank == '0)
        else $error("pin reset missed");
    chk_pin_done: assert property ($rose(power_down_control) |-> powerDownInitDone)
        else $error("pin init missed");
    chk_pin_active: assert property (power_down_control [*4] |-> powerDownActive)
        else $error("pin power-down missed");
    // bit 9 of entry 0F
    chk_reg_done: assert property ($fell(regBank[249]) && $past(writeStrobe) |-> ##2
        powerDownInitDone)
        else $error("register init missed");
    chk_commit_hold: assert property (!$stable({writeAddr, writeData}) |-> writeStrobe)
        else $error("word moved");
    cover property (writeStrobe && writeAddr >= REG_COUNT);
    cover property (softResetPulse);
    cover property ($rose(powerDownInitDone));
endmodule // adc_serial_config_port_asserts
bind adc_serial_config_port adc_serial_config_port_asserts #(.REG_COUNT(REG_COUNT)) u_chk
    (.mclk, .reset_n, .hw_reset_n, .power_down_control, .regBank, .writeStrobe,
    .writeAddr, .writeData, .softResetPulse, .powerDownActive, .powerDownInitDone);

/* verification/tb_top.sv */
// self-checking bench for the configuration port
// assumes host_link and the checker are compiled first
`timescale 1ns/1ps
module tb_top;
    reg mclk = 1'b0;
    reg reset_n = 1'b0;
    reg hw_reset_n = 1'b0;
    reg power_down_control = 1'b0;
    wire cfgShiftClk, cfg_select_n, cfg_serial_in;
    wire [1023:0] regBank;
    wire writeStrobe, softResetPulse, powerDownActive, sleepActive;
    wire powerDownInitDone, partialWordDropped;
    wire [7:0] writeAddr, channelPowerDown;
    wire [15:0] writeData;
    integer num_errors = 0;
    integer n_checks = 0;
    integer pulses = 0;
    integer mdl [0:63];
    integer i, k;
    reg [23:0] expq [$];
    reg [23:0] w;
    always #2.5 mclk = ~mclk;
    host_link u_host_link (.cfgShiftClk, .cfg_select_n, .cfg_serial_in);
    adc_serial_config_port u_adc_serial_config_port (.mclk, .reset_n, .cfgShiftClk,
        .cfg_select_n, .cfg_serial_in, .hw_reset_n, .power_down_control, .regBank,
        .writeStrobe, .writeAddr, .writeData, .softResetPulse, .powerDownActive,
        .sleepActive, .channelPowerDown, .powerDownInitDone, .partialWordDropped);
    task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task test_done;
    begin
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task sw(input [23:0] v);
    begin
        expq.push_back(v);
        for (k = 23; k >= 0; k = k - 1)
            u_host_link.shift_bit(v[k]);
        if (v[23:16] == 8'h00 && v[0])
            for (k = 0; k < 64; k = k + 1)
                mdl[k] = 0;
        else if (v[23:16] < 64)
            mdl[v[23:16]] = v[15:0];
    end
    endtask
    task cb;
    begin
        repeat (10) @(negedge mclk);
        for (i = 0; i < 64; i = i + 1)
            chk("bank", mdl[i][15:0], regBank[i*16 +: 16]);
    end
    endtask
    always @(negedge mclk)
    begin
        if (softResetPulse === 1'b1)
            pulses = pulses + 1;
        if (writeStrobe === 1'b1)
        begin
            w = (expq.size() > 0) ? expq.pop_front() : 24'hFFFFFF;
            chk("addr", {8'h00, w[23:16]}, {8'h00, writeAddr});
            chk("data", w[15:0], writeData);
        end
    end
    initial
    begin
        for (i = 0; i < 64; i = i + 1)
            mdl[i] = 0;
        k = $urandom(56);
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        // registers brought to defaults by the pin straight after power-up
        hw_reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        u_host_link.open_frame;
        for (i = 0; i < 3; i = i + 1)
            sw({8'($urandom_range(63, 1)), 16'($urandom)});
        sw({8'($urandom_range(255, 64)), 16'hA5A5});
        u_host_link.close_frame;
        cb;
        u_host_link.open_frame;
        sw(24'h0F0200);
        for (i = 0; i < 10; i = i + 1)
            u_host_link.shift_bit(1'b1);
        u_host_link.close_frame;
        cb;
        chk("pdact", 16'h1, {15'h0, powerDownActive});
        chk("drop", 16'h1, {15'h0, partialWordDropped});
        u_host_link.open_frame;
        sw(24'h0F0000);
        sw(24'h000001);
        u_host_link.close_frame;
        cb;
        chk("done", 16'h1, {15'h0, powerDownInitDone});
        chk("pulses", 16'h1, pulses[15:0]);
        chk("drop", 16'h0, {15'h0, partialWordDropped});
        u_host_link.open_frame;
        sw({8'h2A, 16'($urandom)});
        sw(24'h0F01C3);
        u_host_link.close_frame;
        cb;
        chk("sleep", {15'h0, mdl[15][8]}, {15'h0, sleepActive});
        chk("chpd", {8'h00, mdl[15][7:0]}, {8'h00, channelPowerDown});
        hw_reset_n = 1'b0;
        repeat (4) @(negedge mclk);
        hw_reset_n = 1'b1;
        for (i = 0; i < 64; i = i + 1)
            mdl[i] = 0;
        cb;
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        chk("done", 16'h0, {15'h0, powerDownInitDone});
        power_down_control = 1'b1;
        repeat (4) @(negedge mclk);
        chk("done", 16'h1, {15'h0, powerDownInitDone});
        chk("pdact", 16'h1, {15'h0, powerDownActive});
        power_down_control = 1'b0;
        repeat (4) @(negedge mclk);
        chk("pdact", 16'h0, {15'h0, powerDownActive});
        // every word shifted in must have produced its own strobe
        chk("pending", 16'h0, 16'(expq.size()));
        test_done;
    end
    initial
    begin
        #200000;
        num_errors = num_errors + 1;
        test_done;
    end
endmodule // tb_top
